// >>> shared/dttp_pkg.sv
// Constants and types shared by the debug, test and trace port
package dttp_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } dttp_tap_t;

  localparam int IR_W = 4;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_DBGCTL = 4'h2;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET_VAL = 4'h1;

  typedef enum logic [1:0] {DR_BYPASS, DR_IDCODE, DR_DBGCTL} dttp_dr_t;

  localparam int DR_W = 32;
  localparam int DCTL_BRK_BIT = 12;
  localparam logic [31:0] DCTL_RESET = 32'h0000_0000;

  localparam logic [2:0] PCST_STL = 3'h7;
  localparam logic [2:0] PCST_JMP = 3'h6;
  localparam logic [2:0] PCST_BRT = 3'h5;
  localparam logic [2:0] PCST_EXP = 3'h4;
  localparam logic [2:0] PCST_SEQ = 3'h3;
  localparam logic [2:0] PCST_TST = 3'h2;
  localparam logic [2:0] PCST_TSQ = 3'h1;
  localparam logic [2:0] PCST_DBM = 3'h0;

  localparam logic [2:0] MULT_X2 = 3'h0;
  localparam logic [2:0] MULT_X3 = 3'h1;
  localparam logic [2:0] MULT_X4 = 3'h2;

  localparam int TRACE_DIV_DEF = 2;
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int PC_W = 32;

endpackage : dttp_pkg

// >>> hdl/dttp_port.sv
// Debug and test port: TAP, real-time trace, boot control and bus observation
//
// Notes on behaviour
// - Each test clock rise in a shift state shifts the input bit into instruction or data register.
// - Test data output changes on the falling test clock edge.
// - Test data output floats when nothing shifts out and during reset.
// - Mode select is sampled on test clock rise and advances the TAP.
// - In enhanced mode the second mode select is sampled on the same edge.
// - Test clock is unrelated to the processor clock; tester gives 50% duty; the probe model holds it high 3 and low at least 7 processor clocks.
// - In trace mode, driving test data input low stops trace, back to scan operation.
// - In trace mode the test data output emits non-sequential program counters.
// - Trace clock is the processor clock divided, for the probe to capture.
// - Three status pins encode stall, jumps, exception, sequential, trace, debug.
// - At cold reset the status pins select the clock multiplier: x2, x3, x4.
// - Debug-boot held during reset gives a debug exception instead of reset.
// - Debug-boot is used as a live level at reset exit; only the break flag latches it.
// - Debug-boot also sets the break request flag, debug control bit 12.
// - Source indicator is high for processor, low for DMA transfers.
// - Debug acknowledge goes low whenever a data acknowledge is returned.
// - Debug strobe goes low at each transaction start with block address out.
// - Instruction/data indicator is low for data, high for instruction fetch.
// - At cold reset the source pin low enables the timer interrupt.
`timescale 1ns/1ps

module dttp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dttp_fifo_st_t;
  dttp_fifo_st_t s_r, s_nxt;
  logic push, pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("FIFO depth must be a power of two of at least 2");
  end

  assign in_ready = (s_r.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign full = !in_ready;
  assign out_data = mem[s_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) s_nxt.wp = s_r.wp + 1'b1;
    if (pop) s_nxt.rp = s_r.rp + 1'b1;
    s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) mem[s_r.wp] <= in_data;
  end
endmodule : dttp_fifo

module dttp_port import dttp_pkg::*; #(
  parameter int TRACE_DIV = TRACE_DIV_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter logic [31:0] ID_CODE = 32'h1234_5001 // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tck,
  input wire logic tdi,
  input wire logic tms,
  input wire logic trst_n,
  input wire logic dbg_tms,
  input wire logic enh_mode,
  output logic tdo_o,
  output logic tdo_oe_n,
  input wire logic trace_start,
  input wire logic pc_valid,
  input wire logic [PC_W-1:0] pc,
  input wire logic [2:0] trace_status,
  output logic trace_dclk,
  output logic trace_active,
  output logic trace_stall,
  input wire logic [2:0] pcst_i,
  output logic [2:0] pcst_o,
  output logic pcst_oe_n,
  output logic [1:0] clk_mult_sel,
  output logic clk_mult_rsvd,
  output logic timer_irq_enable_cfg,
  input wire logic debugboot,
  input wire logic cpu_in_reset,
  output logic take_debug_exc,
  output logic take_reset_exc,
  output logic debug_break_request_flag,
  output logic [31:0] debug_ctrl,
  input wire logic bus_start,
  input wire logic bus_ack,
  input wire logic bus_is_dma,
  input wire logic bus_is_instr,
  input wire logic [31:4] bus_blk_addr,
  output logic [31:4] obs_blk_addr,
  output logic obs_ads_n,
  output logic obs_ack_n,
  input wire logic obs_dma_n_i,
  output logic obs_dma_n,
  output logic obs_i_d_n,
  output logic obs_oe_n
);
  localparam int HALF = TRACE_DIV / 2;

  if (TRACE_DIV < 2 || TRACE_DIV % 2 != 0 || TRACE_DIV > 512) begin : g_chk
    $error("TRACE_DIV must be even, 2 to 512");
  end

  typedef struct packed {
    logic tck_d;
    dttp_tap_t tap;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic [DR_W-1:0] dr_sh;
    logic [31:0] dctl;
    logic tdo;
    logic tdo_oe_n;
    logic trace_on;
    logic [7:0] div_cnt;
    logic dclk;
    logic [2:0] pcst;
    logic pcst_oe_n;
    logic [PC_W-1:0] sh;
    logic [5:0] sh_cnt;
    logic stall;
    logic cfg_done;
    logic [1:0] mult;
    logic mult_rsvd;
    logic tmr_en;
    logic cpu_rst_d;
    logic dbg_exc;
    logic rst_exc;
    logic [31:4] blk;
    logic ads_n;
    logic ack_n;
    logic dma_n;
    logic i_d_n;
    logic obs_oe_n;
  } dttp_st_t;

  dttp_st_t s_r, s_nxt;
  logic tck_rise, tck_fall, tms_eff, dclk_tick;
  logic f_in_ready, f_out_valid, f_out_ready;
  logic [PC_W-1:0] f_out_data;

  function automatic dttp_dr_t dr_of(input logic [IR_W-1:0] ir);
    case (ir)
      IR_IDCODE: dr_of = DR_IDCODE;
      IR_DBGCTL: dr_of = DR_DBGCTL;
      default: dr_of = DR_BYPASS;
    endcase
  endfunction : dr_of

  function automatic dttp_tap_t tap_next(input dttp_tap_t st, input logic m);
    case (st)
      TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      default: tap_next = TAP_RESET;
    endcase
  endfunction : tap_next

  // Test clock is sampled as a plain level, edges found against its last value
  assign tck_rise = tck && !s_r.tck_d;
  assign tck_fall = !tck && s_r.tck_d;
  assign tms_eff = enh_mode ? dbg_tms : tms;
  assign dclk_tick = s_r.trace_on && !s_r.dclk && (s_r.div_cnt == 8'(HALF - 1));
  assign f_out_ready = s_r.trace_on && (s_r.sh_cnt == '0);

  // Holds non-sequential PCs until the serial trace output can take them
  dttp_fifo #(.WIDTH(PC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(s_r.trace_on && pc_valid && (trace_status == PCST_JMP || trace_status == PCST_EXP)),
    .in_ready(f_in_ready),
    .in_data(pc),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data),
    .full()
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.tck_d = tck;
    // TAP
    if (!trst_n) begin
      s_nxt.tap = TAP_RESET;
      s_nxt.ir = IR_RESET_VAL;
    end else if (tck_rise) begin
      s_nxt.tap = tap_next(s_r.tap, tms_eff);
      case (s_r.tap)
        TAP_RESET: s_nxt.ir = IR_RESET_VAL;
        TAP_CAP_IR: s_nxt.ir_sh = IR_CAPTURE;
        TAP_SHIFT_IR: s_nxt.ir_sh = {tdi, s_r.ir_sh[IR_W-1:1]};
        TAP_UPD_IR: s_nxt.ir = s_r.ir_sh;
        TAP_CAP_DR: begin
          case (dr_of(s_r.ir))
            DR_IDCODE: s_nxt.dr_sh = ID_CODE;
            DR_DBGCTL: s_nxt.dr_sh = s_r.dctl;
            default: s_nxt.dr_sh = '0;
          endcase
        end
        TAP_SHIFT_DR: begin
          if (dr_of(s_r.ir) == DR_BYPASS) s_nxt.dr_sh[0] = tdi;
          else s_nxt.dr_sh = {tdi, s_r.dr_sh[DR_W-1:1]};
        end
        TAP_UPD_DR: if (dr_of(s_r.ir) == DR_DBGCTL) s_nxt.dctl = s_r.dr_sh;
        default: s_nxt.ir = s_r.ir;
      endcase
    end
    // Live debug-boot level wins over a scan write of the flag
    if (debugboot) s_nxt.dctl[DCTL_BRK_BIT] = 1'b1;
    // Test data output: scan data on the falling edge, or trace bits
    if (s_r.trace_on) begin
      s_nxt.tdo_oe_n = 1'b0;
      if (dclk_tick) s_nxt.tdo = s_r.sh[0];
    end else if (tck_fall) begin
      s_nxt.tdo_oe_n = !(s_r.tap == TAP_SHIFT_IR || s_r.tap == TAP_SHIFT_DR);
      s_nxt.tdo = (s_r.tap == TAP_SHIFT_IR) ? s_r.ir_sh[0] : s_r.dr_sh[0];
    end
    // Trace mode entry and exit
    if (s_r.trace_on && !tdi) s_nxt.trace_on = 1'b0;
    else if (trace_start && s_r.cfg_done) s_nxt.trace_on = 1'b1;
    // Trace clock and status
    if (!s_r.trace_on) begin
      s_nxt.div_cnt = '0;
      s_nxt.dclk = 1'b0;
      s_nxt.sh_cnt = '0;
    end else if (s_r.div_cnt == 8'(HALF - 1)) begin
      s_nxt.div_cnt = '0;
      s_nxt.dclk = !s_r.dclk;
    end else begin
      s_nxt.div_cnt = s_r.div_cnt + 8'h01;
    end
    if (dclk_tick) s_nxt.pcst = trace_status;
    if (f_out_valid && f_out_ready) begin
      s_nxt.sh = f_out_data;
      s_nxt.sh_cnt = 6'(PC_W);
    end else if (dclk_tick && s_r.sh_cnt != '0) begin
      s_nxt.sh = {1'b0, s_r.sh[PC_W-1:1]};
      s_nxt.sh_cnt = s_r.sh_cnt - 6'h01;
    end
    s_nxt.stall = !f_in_ready;
    // Cold reset straps read while all pin drivers are still off
    if (!s_r.cfg_done) begin
      s_nxt.cfg_done = 1'b1;
      s_nxt.mult = pcst_i[1:0];
      s_nxt.mult_rsvd = !(pcst_i == MULT_X2 || pcst_i == MULT_X3 || pcst_i == MULT_X4);
      s_nxt.tmr_en = !obs_dma_n_i;
      s_nxt.pcst_oe_n = 1'b0;
      s_nxt.obs_oe_n = 1'b0;
    end
    // Exception choice as the core leaves reset
    s_nxt.cpu_rst_d = cpu_in_reset;
    s_nxt.dbg_exc = s_r.cpu_rst_d && !cpu_in_reset && debugboot;
    s_nxt.rst_exc = s_r.cpu_rst_d && !cpu_in_reset && !debugboot;
    // Bus observation
    s_nxt.ads_n = !bus_start;
    s_nxt.ack_n = !bus_ack;
    if (bus_start) s_nxt.blk = bus_blk_addr;
    if (bus_start || bus_ack) begin
      s_nxt.dma_n = !bus_is_dma;
      s_nxt.i_d_n = bus_is_instr;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.tap <= TAP_RESET;
      s_r.ir <= IR_RESET_VAL;
      s_r.dctl <= DCTL_RESET;
      s_r.tdo_oe_n <= 1'b1;
      s_r.pcst_oe_n <= 1'b1;
      s_r.pcst <= PCST_DBM;
      s_r.ads_n <= 1'b1;
      s_r.ack_n <= 1'b1;
      s_r.dma_n <= 1'b1;
      s_r.i_d_n <= 1'b1;
      s_r.obs_oe_n <= 1'b1;
      s_r.cpu_rst_d <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tdo_o = s_r.tdo;
  assign tdo_oe_n = s_r.tdo_oe_n;
  assign trace_dclk = s_r.dclk;
  assign trace_active = s_r.trace_on;
  assign trace_stall = s_r.stall;
  assign pcst_o = s_r.pcst;
  assign pcst_oe_n = s_r.pcst_oe_n;
  assign clk_mult_sel = s_r.mult;
  assign clk_mult_rsvd = s_r.mult_rsvd;
  assign timer_irq_enable_cfg = s_r.tmr_en;
  assign take_debug_exc = s_r.dbg_exc;
  assign take_reset_exc = s_r.rst_exc;
  assign debug_break_request_flag = s_r.dctl[DCTL_BRK_BIT];
  assign debug_ctrl = s_r.dctl;
  assign obs_blk_addr = s_r.blk;
  assign obs_ads_n = s_r.ads_n;
  assign obs_ack_n = s_r.ack_n;
  assign obs_dma_n = s_r.dma_n;
  assign obs_i_d_n = s_r.i_d_n;
  assign obs_oe_n = s_r.obs_oe_n;

  AST_TRST_RESETS_TAP: assert property (@(posedge core_clk) disable iff (!arst_n)
    !trst_n |=> s_r.tap == TAP_RESET)
    else $error("TAP not in reset after test reset");
  AST_TDO_DRIVE_SHIFT: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!s_r.trace_on && !trace_start && tck_fall && s_r.tap == TAP_SHIFT_DR)
      |=> !tdo_oe_n)
    else $error("Output driver off while shifting data");
  AST_TDO_FALL_ONLY: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!s_r.trace_on && !$past(s_r.trace_on) && $changed(tdo_o)) |-> $past(tck_fall))
    else $error("Scan output changed away from falling test clock");
  AST_TDO_Z_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!s_r.trace_on && !trace_start && tck_fall && s_r.tap == TAP_IDLE) |=> tdo_oe_n)
    else $error("Output driven with nothing to shift");
  AST_BOOT_FLAG: assert property (@(posedge core_clk) disable iff (!arst_n)
    debugboot |=> debug_break_request_flag)
    else $error("Debug-boot did not set the break flag");
  AST_BOOT_EXC: assert property (@(posedge core_clk) disable iff (!arst_n)
    ($past(cpu_in_reset) && !cpu_in_reset && debugboot) ##1 1'b1
      |-> take_debug_exc && !take_reset_exc ##1 !take_debug_exc)
    else $error("Debug exception not taken at end of reset");
  AST_STROBE_SOURCE: assert property (@(posedge core_clk) disable iff (!arst_n)
    bus_start |=> !obs_ads_n && obs_dma_n == !$past(bus_is_dma))
    else $error("Strobe or source indicator wrong");
  AST_ACK_LOW: assert property (@(posedge core_clk) disable iff (!arst_n)
    bus_ack |=> !obs_ack_n && obs_i_d_n == $past(bus_is_instr))
    else $error("Acknowledge or fetch indicator wrong");
  AST_TRACE_STOP: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_r.trace_on && !tdi) |=> !trace_active [*2])
    else $error("Trace did not stop on test data input");
  AST_DCLK_PERIOD: assert property (@(posedge core_clk) disable iff (!arst_n)
    (trace_active && $past(trace_active)) |->
      ($changed(trace_dclk) == ($past(s_r.div_cnt) == 8'(HALF - 1))))
    else $error("Trace clock wrong");
endmodule : dttp_port

// >>> dv/dttp_probe.sv
// Probe model: drives test clock, mode selects and test data in
`timescale 1ns/1ps
module dttp_probe (
  input wire logic core_clk,
  input wire logic enh,
  input wire logic tdo_o,
  input wire logic tdo_oe_n,
  output logic tck,
  output logic tms,
  output logic dbg_tms,
  output logic tdi
);
  // Test clock stands low between scans, selects and data in pulled up
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    dbg_tms = 1'b1;
    tdi = 1'b1;
  end
  // The unused mode select carries the opposite level to expose a wrong pick
  task automatic step(input logic m, input logic d, output logic q);
    tms <= enh ? !m : m;
    dbg_tms <= enh ? m : !m;
    tdi <= d;
    repeat (3) @(posedge core_clk);
    tck <= 1'b1;
    repeat (3) @(posedge core_clk);
    tck <= 1'b0;
    repeat (4) @(posedge core_clk);
    // Released output reads as the inverse, so a bit taken while undriven shows up
    q = tdo_oe_n ? !tdo_o : tdo_o;
  endtask : step
  task automatic dint(input logic v);
    tdi <= v;
  endtask : dint
endmodule : dttp_probe

// >>> dv/testbench.sv
// Self-checking bench for the debug, test and trace port
`timescale 1ns/1ps
module testbench;
  import dttp_pkg::*;
  localparam logic [31:0] IDV = 32'h0A5C_3E71; // Arbitrary identity value
  logic core_clk = 1'b0;
  logic arst_n, trst_n, enh_mode, trace_start, pc_valid, debugboot, cpu_in_reset;
  logic bus_start, bus_ack, bus_is_dma, bus_is_instr, obs_dma_n_i, tck, tdi, tms, dbg_tms;
  logic tdo_o, tdo_oe_n, trace_dclk, trace_active, trace_stall, pcst_oe_n, clk_mult_rsvd;
  logic timer_irq_enable_cfg, take_debug_exc, take_reset_exc, debug_break_request_flag;
  logic obs_ads_n, obs_ack_n, obs_dma_n, obs_i_d_n, obs_oe_n, dprev;
  logic [2:0] trace_status, pcst_i, pcst_o;
  logic [1:0] clk_mult_sel;
  logic [31:4] bus_blk_addr, obs_blk_addr;
  logic [31:0] pc, debug_ctrl, q, r, pv;
  logic [31:0] rs = 32'h0000_0F5A;
  logic [63:0] win;
  int fails = 0;
  int n_checks = 0;
  int nr, ns;
  always #12.5 core_clk = ~core_clk;
  dttp_port #(.ID_CODE(IDV)) uut (.core_clk, .arst_n, .tck, .tdi, .tms, .trst_n, .dbg_tms,
    .enh_mode, .tdo_o, .tdo_oe_n, .trace_start, .pc_valid, .pc, .trace_status, .trace_dclk,
    .trace_active, .trace_stall, .pcst_i, .pcst_o, .pcst_oe_n, .clk_mult_sel, .clk_mult_rsvd,
    .timer_irq_enable_cfg, .debugboot, .cpu_in_reset, .take_debug_exc, .take_reset_exc,
    .debug_break_request_flag, .debug_ctrl, .bus_start, .bus_ack, .bus_is_dma, .bus_is_instr,
    .bus_blk_addr, .obs_blk_addr, .obs_ads_n, .obs_ack_n, .obs_dma_n_i, .obs_dma_n,
    .obs_i_d_n, .obs_oe_n);
  dttp_probe probe (.core_clk, .enh(enh_mode), .tdo_o, .tdo_oe_n, .tck, .tms, .dbg_tms, .tdi);
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic walk(input logic [3:0] ms, input int k);
    logic b;
    for (int i = 0; i < k; i++) probe.step(ms[i], 1'b1, b);
  endtask : walk
  // Enters shift from capture, shifts n bits LSB first, ends in idle
  task automatic scan(input int n, input logic [31:0] d, output logic [31:0] o);
    logic b;
    o = '0;
    probe.step(1'b0, 1'b1, b);
    o[0] = b;
    chk(tdo_oe_n, 0, "tdo_oe_n shift");
    for (int i = 0; i < n; i++) begin
      probe.step(i == n - 1, d[i], b);
      if (i < n - 1) o[i + 1] = b;
    end
    walk(4'h1, 2);
    chk(tdo_oe_n, 1, "tdo_oe_n idle");
  endtask : scan
  task automatic bus_run(input int n);
    logic s, a, dm, ins, edma, eid;
    logic [31:4] ad;
    {s, a, dm, ins, edma, eid, ad} = {6'h3, 28'h0};
    for (int i = 0; i <= n; i++) begin
      r = (i < n) ? xs() : 32'h0;
      pv = xs();
      @(posedge core_clk);
      {bus_start, bus_ack, bus_is_dma, bus_is_instr} <= r[3:0];
      bus_blk_addr <= pv[31:4];
      @(negedge core_clk);
      if (s || a) {edma, eid} = {!dm, ins};
      chk(obs_ads_n, !s, "obs_ads_n");
      chk(obs_ack_n, !a, "obs_ack_n");
      chk(obs_dma_n, edma, "obs_dma_n");
      chk(obs_i_d_n, eid, "obs_i_d_n");
      if (s) chk(obs_blk_addr, ad, "obs_blk_addr");
      {s, a, dm, ins, ad} = {r[3:0], pv[31:4]};
    end
  endtask : bus_run
  task automatic boot(input logic a, input logic b, input logic e);
    int nd, nx;
    nd = 0;
    nx = 0;
    @(posedge core_clk);
    cpu_in_reset <= 1'b1;
    debugboot <= a;
    cyc(4);
    debugboot <= b;
    cyc(2);
    cpu_in_reset <= 1'b0;
    repeat (5) begin
      @(negedge core_clk);
      nd += (take_debug_exc === 1'b1);
      nx += (take_reset_exc === 1'b1);
    end
    chk(nd, e, "debug exception");
    chk(nx, !e, "reset exception");
    @(posedge core_clk);
    debugboot <= 1'b0;
  endtask : boot
  initial begin
    cyc(20000);
    fails++;
    summarize();
  end
  initial begin
    {arst_n, trst_n, enh_mode, trace_start, pc_valid, debugboot, cpu_in_reset} = '0;
    {bus_start, bus_ack, bus_is_dma, bus_is_instr, obs_dma_n_i} = '0;
    {pc, trace_status, pcst_i, bus_blk_addr} = {32'h0, 3'h0, 3'h1, 28'h0};
    cyc(3);
    chk({tdo_oe_n, pcst_oe_n, obs_oe_n}, 3'h7, "drivers in reset");
    arst_n <= 1'b1;
    cyc(3);
    chk(clk_mult_sel, MULT_X3[1:0], "clk_mult_sel");
    chk(timer_irq_enable_cfg, 1, "timer_irq_enable_cfg");
    chk({clk_mult_rsvd, pcst_oe_n, obs_oe_n}, 3'h0, "straps drivers on");
    trst_n <= 1'b1;
    cyc(2);
    walk(4'h0, 1);
    chk(tdo_oe_n, 1, "tdo_oe_n idle");
    walk(4'h3, 3);
    scan(4, IR_BYPASS, q);
    chk(q[3:0], IR_CAPTURE, "ir capture");
    walk(4'h1, 2);
    r = xs();
    scan(8, r, q);
    chk(q[7:0], {r[6:0], 1'b0}, "bypass");
    walk(4'h3, 3);
    scan(4, IR_IDCODE, q);
    enh_mode <= 1'b1;
    cyc(1);
    walk(4'h1, 2);
    scan(32, xs(), q);
    chk(q, IDV, "idcode");
    enh_mode <= 1'b0;
    bus_run(200);
    boot(1'b1, 1'b1, 1'b1);
    chk({debug_break_request_flag, debug_ctrl[12]}, 2'h3, "break flag");
    boot(1'b0, 1'b0, 1'b0);
    boot(1'b1, 1'b0, 1'b0);
    // Debug control read shows the boot flag, then a scan write clears it
    walk(4'h3, 3);
    scan(4, IR_DBGCTL, q);
    walk(4'h1, 2);
    pv = xs() & ~(32'h0000_0001 << DCTL_BRK_BIT);
    scan(32, pv, q);
    chk(q, DCTL_RESET | (32'h0000_0001 << DCTL_BRK_BIT), "dbgctl read");
    chk(debug_ctrl, pv, "dbgctl write");
    trace_start <= 1'b1;
    cyc(1);
    trace_start <= 1'b0;
    cyc(2);
    chk(trace_active, 1, "trace_active");
    for (int c = 0; c < 8; c++) begin
      trace_status <= c[2:0];
      cyc(8);
      chk(pcst_o, c, "pcst_o");
    end
    pv = xs();
    trace_status <= PCST_JMP;
    pc_valid <= 1'b1;
    pc <= pv;
    cyc(1);
    pc_valid <= 1'b0;
    {nr, dprev, win} = {32'h0, 1'b1, ~{pv, pv}};
    repeat (100) begin
      @(negedge core_clk);
      if (trace_dclk && !dprev) {nr, win} = {nr + 1, tdo_o, win[63:1]};
      dprev = trace_dclk;
    end
    chk(nr > 48 && nr < 51, 1, "dclk rises");
    ns = 0;
    for (int k = 0; k <= 32; k++) ns += (win[k +: 32] === pv);
    chk(ns > 0, 1, "traced pc");
    ns = 0;
    @(posedge core_clk);
    pc_valid <= 1'b1;
    repeat (12) begin
      pc <= xs();
      cyc(1);
      ns += (trace_stall === 1'b1);
    end
    pc_valid <= 1'b0;
    chk(ns > 0, 1, "fifo full");
    for (int k = 0; k < 1500 && trace_stall !== 1'b0; k++) cyc(1);
    chk(trace_stall, 0, "fifo drained");
    probe.dint(1'b0);
    cyc(3);
    chk(trace_active, 0, "trace stop");
    probe.dint(1'b1);
    cyc(2);
    // Second cold reset with a reserved multiplier code and the timer disabled
    pcst_i <= 3'h5;
    obs_dma_n_i <= 1'b1;
    arst_n <= 1'b0;
    cyc(3);
    chk({tdo_oe_n, pcst_oe_n, obs_oe_n}, 3'h7, "drivers in reset again");
    arst_n <= 1'b1;
    cyc(3);
    chk({clk_mult_rsvd, timer_irq_enable_cfg}, 2'h2, "straps again");
    summarize();
  end
endmodule : testbench
